// File: sbsf_core.sv
// serial bit-rate generator, byte shifter and status flags behind an ahb-lite slave
`timescale 1ns/1ps
//
// Behaviour
// - prescale field bits 6:4 divides by code plus one
// - bus clock feeds prescaler, prescaler feeds divider
// - rate field bits 2:0 divides by two..256
// - divider output clocks serial bits as master
// - bit-rate register accessible at any time
// - status unused bits zero, writes ignored
// - transfer end sets receive-full in bit 7
// - receive-full clears by status then data read
// - buffer-to-shifter move sets transmit-empty bit 5
// - transmit-empty clears by status read then write
// - data write without prior status read ignored
// - transmit interrupt from flag and enable
// - idle shifter takes byte, flag back quickly
// - queued byte loads automatically after shift
// - low select as master sets mode-fault bit 4
// - fault input only with master, enable, no output
// - mode-fault clears by status read then control write
// - receive interrupt from receive-full or mode-fault
// - disable aborts, clears receive-full, sets transmit-empty
// - overrun keeps old byte, drops new one
module sbsf_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial link pins
  output logic sck_out,
  output logic sck_oe,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic select_n_in,
  output logic select_n_out,
  output logic select_oe,
  // interrupt requests
  output logic tx_irq,
  output logic rx_irq
);
  import sbsf_pkg::*;

  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] serial_bit_rate_control;
  logic pend;
  logic pend_write;
  logic [7:0] pend_addr;
  logic [7:0] tx_buf;
  logic tx_full;
  logic [7:0] rx_buf;
  logic [7:0] shifter;
  logic rx_sample;
  logic [3:0] edge_cnt;
  logic [2:0] pre_cnt;
  logic [7:0] div_cnt;
  sbsf_state_t state;
  logic receive_full_flag;
  logic transmit_empty_flag;
  logic mode_fault_flag;
  logic rx_arm;
  logic tx_arm;
  logic mf_arm;

  // bus decode
  wire accept = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire do_wr = pend & pend_write;
  wire do_rd = pend & ~pend_write;
  wire wr_c1 = do_wr & (pend_addr == ADDR_CTRL1);
  wire wr_c2 = do_wr & (pend_addr == ADDR_CTRL2);
  wire wr_rate = do_wr & (pend_addr == ADDR_RATE);
  wire wr_data = do_wr & (pend_addr == ADDR_DATA);
  wire rd_status = do_rd & (pend_addr == ADDR_STATUS);
  wire rd_data = do_rd & (pend_addr == ADDR_DATA);

  // control fields
  wire interface_enable = ctrl1[C1_IFACE_EN];
  wire master_select = ctrl1[C1_MASTER];
  wire select_output_enable = ctrl1[C1_SEL_OE];
  wire transmit_irq_enable = ctrl1[C1_TX_IRQ_EN];
  wire receive_irq_enable = ctrl1[C1_RX_IRQ_EN];
  wire mode_fault_enable = ctrl2[C2_MF_EN];
  wire [2:0] prescale_select = serial_bit_rate_control[RATE_PRE_HI:RATE_PRE_LO];
  wire [2:0] rate_divisor_select = serial_bit_rate_control[RATE_DIV_HI:RATE_DIV_LO];
  wire run = interface_enable & master_select;

  // status image, unused bits tied low
  wire [7:0] status_word = {receive_full_flag, 1'b0, transmit_empty_flag, mode_fault_flag,
                            4'h0};

  // read multiplexer; unmapped addresses read zero
  wire [7:0] read_byte = (pend_addr == ADDR_CTRL1) ? ctrl1 :
                         (pend_addr == ADDR_CTRL2) ? ctrl2 :
                         (pend_addr == ADDR_RATE) ? serial_bit_rate_control :
                         (pend_addr == ADDR_STATUS) ? status_word :
                         (pend_addr == ADDR_DATA) ? rx_buf : BYTE_ZERO;

  // prescaler fed from the bus clock, ticks once per code+1 cycles
  wire pre_tick = (pre_cnt == prescale_select);
  wire [2:0] next_pre_cnt = (~run | pre_tick) ? PRE_ZERO : pre_cnt + 3'h1;
  // divider counts prescaler ticks; half the divisor between serial clock edges
  wire [7:0] half_div = DIV_ONE << rate_divisor_select;
  wire div_end = pre_tick & (div_cnt == half_div - DIV_ONE);
  wire [7:0] next_div_cnt = (~run | div_end) ? BYTE_ZERO :
                            pre_tick ? div_cnt + DIV_ONE : div_cnt;
  // a serial edge is one divider wrap while shifting
  wire sck_edge = run & (state == SBSF_SHIFT) & div_end;

  // transfer sequencing
  wire load_shift = run & (state == SBSF_IDLE) & tx_full;
  wire xfer_done = sck_edge & (edge_cnt == LAST_EDGE);
  wire data_write_ok = wr_data & tx_arm;
  wire rx_load = xfer_done & (~receive_full_flag | (rd_data & rx_arm));
  // fault input is qualified by master, fault enable and no select output
  wire mf_event = run & mode_fault_enable & ~select_output_enable & ~select_n_in;
  // mosi changes only at load and falling edges, at least a cycle ahead of each rising sample
  wire mosi_move = load_shift | (sck_edge & sck_out);
  wire next_mosi = load_shift ? tx_buf[7] : shifter[6];
  // select drops with the load so the first bit is set up before the first rising edge
  wire frame_active = load_shift | ((state == SBSF_SHIFT) & run & ~xfer_done);

  // bus address phase capture; one wait state so reads see prior writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend <= 1'b0;
      pend_write <= 1'b0;
      pend_addr <= BYTE_ZERO;
      hreadyout <= 1'b1;
    end else begin
      pend <= accept;
      hreadyout <= ~accept;
      if (accept) begin
        pend_write <= hwrite;
        pend_addr <= haddr;
      end
    end
  end

  // read data and fixed okay response
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else if (do_rd) begin
      hrdata <= {24'h00_0000, read_byte};
    end
  end

  // control registers; bit-rate writable any time, status writes dropped
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl1 <= CTRL1_RESET;
      ctrl2 <= CTRL2_RESET;
      serial_bit_rate_control <= RATE_RESET;
    end else begin
      if (wr_c1) ctrl1 <= hwdata[7:0];
      if (wr_c2) ctrl2 <= hwdata[7:0];
      if (wr_rate) serial_bit_rate_control <= {1'b0, hwdata[6:4], 1'b0, hwdata[2:0]};
    end
  end

  // rate counters
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pre_cnt <= PRE_ZERO;
      div_cnt <= BYTE_ZERO;
    end else begin
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
    end
  end

  // transmit buffer; disable empties it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_full <= 1'b0;
      tx_buf <= BYTE_ZERO;
    end else if (~interface_enable) begin
      tx_full <= 1'b0;
    end else if (data_write_ok) begin
      tx_full <= 1'b1;
      tx_buf <= hwdata[7:0];
    end else if (load_shift) begin
      tx_full <= 1'b0;
    end
  end

  // shifter: mode-0 msb first, sample on rising, shift on falling; disable aborts
  always_ff @(posedge ref_clk) begin
    if (reset | ~run) begin
      state <= SBSF_IDLE;
      edge_cnt <= 4'h0;
      shifter <= BYTE_ZERO;
      sck_out <= 1'b0;
      rx_sample <= 1'b0;
    end else if (load_shift) begin
      state <= SBSF_SHIFT;
      edge_cnt <= 4'h0;
      shifter <= tx_buf;
    end else if (sck_edge) begin
      sck_out <= ~sck_out;
      edge_cnt <= edge_cnt + 4'h1;
      // held apart so the outgoing lsb is not overwritten before it is sent
      if (~sck_out) rx_sample <= miso_in;
      else shifter <= {shifter[6:0], rx_sample};
      if (xfer_done) state <= SBSF_IDLE;
    end
  end

  // pin drivers registered from shifter state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mosi_out <= 1'b0;
      sck_oe <= 1'b0;
      select_n_out <= 1'b1;
      select_oe <= 1'b0;
    end else begin
      if (mosi_move) mosi_out <= next_mosi;
      sck_oe <= run;
      select_n_out <= ~frame_active;
      select_oe <= run & mode_fault_enable & select_output_enable;
    end
  end

  // receive buffer keeps the older byte on overrun
  always_ff @(posedge ref_clk) begin
    if (reset) rx_buf <= BYTE_ZERO;
    else if (rx_load) rx_buf <= {shifter[6:0], rx_sample};
  end

  // receive-full: new byte sets, armed data read clears, set wins
  always_ff @(posedge ref_clk) begin
    if (reset | ~interface_enable) begin
      receive_full_flag <= 1'b0;
      rx_arm <= 1'b0;
    end else begin
      if (rx_load) receive_full_flag <= 1'b1;
      else if (rd_data & rx_arm) receive_full_flag <= 1'b0;
      if (rd_status & receive_full_flag) rx_arm <= 1'b1;
      else if (rd_data) rx_arm <= 1'b0;
    end
  end

  // transmit-empty: set on move to shifter, cleared by armed data write
  always_ff @(posedge ref_clk) begin
    if (reset | ~interface_enable) begin
      transmit_empty_flag <= 1'b1;
      tx_arm <= 1'b0;
    end else begin
      if (load_shift) transmit_empty_flag <= 1'b1;
      else if (data_write_ok) transmit_empty_flag <= 1'b0;
      if (rd_status & transmit_empty_flag) tx_arm <= 1'b1;
      else if (wr_data) tx_arm <= 1'b0;
    end
  end

  // mode-fault: set by qualified low select, armed control write clears, set wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_fault_flag <= 1'b0;
      mf_arm <= 1'b0;
    end else begin
      if (mf_event) mode_fault_flag <= 1'b1;
      else if (wr_c1 & mf_arm) mode_fault_flag <= 1'b0;
      if (rd_status & mode_fault_flag) mf_arm <= 1'b1;
      else if (wr_c1) mf_arm <= 1'b0;
    end
  end

  // interrupt requests, registered so they lag the flags by one cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      tx_irq <= transmit_empty_flag & transmit_irq_enable;
      rx_irq <= (receive_full_flag | mode_fault_flag) & receive_irq_enable;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_prescale_tick: assert property (
    run & ~pre_tick |=> pre_cnt == $past(pre_cnt) + 3'h1 || ~run || $changed(prescale_select))
    else $error("prescaler did not advance");
  a_divider_half: assert property (
    div_end |-> div_cnt == (DIV_ONE << rate_divisor_select) - DIV_ONE)
    else $error("divider wrapped at wrong count");
  a_sck_toggle: assert property (
    sck_edge & ~xfer_done & ~load_shift |=> sck_out != $past(sck_out))
    else $error("serial clock missed an edge");
  a_status_zero: assert property (
    rd_status |=> hrdata[6] == 1'b0 && hrdata[3:0] == 4'h0)
    else $error("status unused bits not zero");
  a_rx_set: assert property (
    xfer_done |=> receive_full_flag || ~interface_enable)
    else $error("receive-full not set at transfer end");
  a_rx_hold: assert property (
    receive_full_flag & interface_enable & ~(rd_data & rx_arm) |=> receive_full_flag)
    else $error("receive-full dropped without clear sequence");
  a_tx_ignore: assert property (
    wr_data & ~tx_arm & ~tx_full & ~load_shift & interface_enable |=> ~tx_full)
    else $error("unarmed data write accepted");
  a_tx_refill: assert property (
    data_write_ok & run & state == SBSF_IDLE |-> ##[1:2] transmit_empty_flag)
    else $error("transmit-empty not back within two cycles");
  a_tx_irq: assert property (
    transmit_empty_flag & transmit_irq_enable |=> tx_irq)
    else $error("transmit interrupt missing");
  a_mf_qual: assert property (
    ~mode_fault_flag & ~(run & mode_fault_enable & ~select_output_enable) |=> ~mode_fault_flag)
    else $error("mode fault set while not qualified");
  a_rx_irq: assert property (
    (receive_full_flag | mode_fault_flag) & receive_irq_enable |=> rx_irq)
    else $error("receive interrupt missing");
  a_disable_flags: assert property (
    ~interface_enable |=> ~receive_full_flag && transmit_empty_flag && state == SBSF_IDLE)
    else $error("disable did not reset flags");
  a_overrun_keep: assert property (
    xfer_done & receive_full_flag & ~(rd_data & rx_arm) |=> rx_buf == $past(rx_buf))
    else $error("overrun replaced old byte");

  // bus handshake, counter wraps, flag sequences and pin timing
  a_hready_wait: assert property (
    accept |=> ~hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  a_resp_okay: assert property (
    ~hresp)
    else $error("response not okay");
  a_rate_write: assert property (
    wr_rate |=> serial_bit_rate_control == {1'b0, $past(hwdata[RATE_PRE_HI:RATE_PRE_LO]),
                                            1'b0, $past(hwdata[RATE_DIV_HI:RATE_DIV_LO])})
    else $error("bit-rate write not stored");
  a_pre_wrap: assert property (
    run & pre_tick |=> pre_cnt == PRE_ZERO)
    else $error("prescaler did not wrap");
  a_div_reset: assert property (
    div_end |=> div_cnt == BYTE_ZERO)
    else $error("divider did not restart");
  a_rx_clear: assert property (
    rd_data & rx_arm & ~rx_load & interface_enable |=> ~receive_full_flag)
    else $error("receive-full not cleared by sequence");
  a_tx_load: assert property (
    load_shift |=> transmit_empty_flag)
    else $error("transmit-empty not set on load");
  a_tx_clear: assert property (
    data_write_ok & ~load_shift & interface_enable |=> ~transmit_empty_flag)
    else $error("transmit-empty not cleared by write");
  a_tx_queue: assert property (
    xfer_done & tx_full |=> load_shift || ~run)
    else $error("queued byte not loaded");
  a_mf_set: assert property (
    mf_event |=> mode_fault_flag)
    else $error("mode fault not set");
  a_mf_clear: assert property (
    wr_c1 & mf_arm & ~mf_event |=> ~mode_fault_flag)
    else $error("mode fault not cleared by sequence");
  a_sck_idle: assert property (
    state == SBSF_IDLE |-> ~sck_out)
    else $error("serial clock not idle low");
  a_mosi_setup: assert property (
    sck_edge & ~sck_out |=> mosi_out == $past(mosi_out))
    else $error("mosi changed at a rising edge");
endmodule

// File: sbsf_pkg.sv
// constants and types for the serial bit-rate and status-flag block
package sbsf_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_RATE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  // first control register fields
  localparam int C1_RX_IRQ_EN = 7;
  localparam int C1_IFACE_EN = 6;
  localparam int C1_TX_IRQ_EN = 5;
  localparam int C1_MASTER = 4;
  localparam int C1_SEL_OE = 1;
  // second control register field
  localparam int C2_MF_EN = 4;
  // bit-rate register fields
  localparam int RATE_PRE_HI = 6;
  localparam int RATE_PRE_LO = 4;
  localparam int RATE_DIV_HI = 2;
  localparam int RATE_DIV_LO = 0;
  // status register fields
  localparam int ST_RX_FULL = 7;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_MODE_FAULT = 4;
  // reset values
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h00;
  // one byte takes sixteen serial clock edges
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [7:0] DIV_ONE = 8'h01;
  localparam logic [2:0] PRE_ZERO = 3'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // shifter states
  typedef enum logic {
    SBSF_IDLE = 1'b0,
    SBSF_SHIFT = 1'b1
  } sbsf_state_t;
endpackage

// File: sbsf_peer.sv
// serial peer model: mode 0 slave that echoes each received byte in the next frame
`timescale 1ns/1ps
module sbsf_peer (
  // serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic select_n,
  output logic miso,
  // last received byte and count of whole bytes
  output logic [7:0] rx_byte,
  output logic [7:0] frames
);
  logic [7:0] sh = 8'h3C;
  logic [7:0] rxs = 8'h00;
  logic [2:0] bits = 3'h0;
  initial begin
    rx_byte = 8'h00;
    frames = 8'h00;
  end
  // a released line shows the inverse bit so a stale value never passes
  assign miso = select_n ? ~sh[7] : sh[7];
  // sample on the rising edge, msb first; a raised select restarts a cut frame
  always @(posedge sck or posedge select_n) begin
    if (select_n) begin
      bits = 3'h0;
    end else begin
      rxs = {rxs[6:0], mosi};
      bits = bits + 3'h1;
      if (bits == 3'h0) begin
        rx_byte = rxs;
        frames = frames + 8'h01;
      end
    end
  end
  // shift on the falling edge; after a whole byte, load the echo
  always @(negedge sck) begin
    sh = (bits == 3'h0) ? rx_byte : {sh[6:0], 1'b0};
  end
endmodule

// File: tb_spi_baud_and_status_flags.sv
// self-checking bench for the serial bit-rate and status-flag block
`timescale 1ns/1ps
module tb_spi_baud_and_status_flags;
  import sbsf_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic select_n_in = 1'b1;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sck_out, sck_oe, mosi_out, miso_in, select_n_out, select_oe;
  logic tx_irq, rx_irq;
  logic [7:0] rx_byte, frames;
  logic [31:0] lfsr = 32'h6b64_2b68;
  logic [31:0] rd;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  sbsf_core i_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_out(mosi_out), .miso_in(miso_in), .select_n_in(select_n_in),
    .select_n_out(select_n_out), .select_oe(select_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
  sbsf_peer i_peer (.sck(sck_out), .mosi(mosi_out), .select_n(select_n_out),
    .miso(miso_in), .rx_byte(rx_byte), .frames(frames));
  // random source and expected serial clock period in bus cycles
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] period(input logic [2:0] p, input logic [2:0] r);
    return 32'(p + 1) << (r + 1);
  endfunction
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_word(what, {31'h0, exp}, {31'h0, got});
  endtask
  // one ahb-lite single transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    cmp_word(what, exp, rd);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, well above the longest rate setting used
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    logic [2:0] p, r;
    logic [31:0] c;
    logic f;
    time t1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    // enabled master, both interrupts on; a data write before any status read
    wr(ADDR_CTRL1, 32'h0000_00F0);
    // irq and pin enables are registered one edge after the write lands
    @(posedge ref_clk);
    cmp_bit("tx irq", 1'b1, tx_irq);
    cmp_bit("sck oe", 1'b1, sck_oe);
    cmp_bit("hresp", 1'b0, hresp);
    wr(ADDR_DATA, 32'h0000_005A);
    repeat (40) @(posedge ref_clk);
    cmp_bit("select idle", 1'b1, select_n_out);
    rchk("rate rst", ADDR_RATE, 32'h0000_0000);
    rchk("status", ADDR_STATUS, 32'h0000_0020);
    wr(ADDR_STATUS, 32'h0000_00FF);
    rchk("status wr", ADDR_STATUS, 32'h0000_0020);
    wr(8'h14, 32'h0000_00FF);
    rchk("hole", 8'h14, 32'h0000_0000);
    // two bytes back to back at four cycles a bit, second one queued
    wr(ADDR_RATE, 32'h0000_0010);
    wr(ADDR_DATA, 32'h0000_00A5);
    rchk("te back", ADDR_STATUS, 32'h0000_0020);
    wr(ADDR_DATA, 32'h0000_00C3);
    rchk("te clear", ADDR_STATUS, 32'h0000_0000);
    cmp_bit("tx irq off", 1'b0, tx_irq);
    wait (frames == 8'h01);
    repeat (4) @(posedge ref_clk);
    cmp_word("mosi byte", 32'h0000_00A5, {24'h0, rx_byte});
    rchk("rx data", ADDR_DATA, 32'h0000_003C);
    rchk("rf kept", ADDR_STATUS, 32'h0000_00A0);
    cmp_bit("rx irq", 1'b1, rx_irq);
    wait (frames == 8'h02);
    repeat (4) @(posedge ref_clk);
    cmp_word("queued byte", 32'h0000_00C3, {24'h0, rx_byte});
    rchk("overrun", ADDR_DATA, 32'h0000_003C);
    rchk("rf clear", ADDR_STATUS, 32'h0000_0020);
    // rate codes: both corners, then random; each transfer cut short by disable
    for (int i = 0; i < 6; i++) begin
      lfsr = step(lfsr);
      p = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : lfsr[6:4];
      r = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : lfsr[2:0];
      c = {25'h0, p, 1'b0, r};
      wr(ADDR_CTRL1, 32'h0000_0050);
      wr(ADDR_RATE, c);
      rchk("rate", ADDR_RATE, c);
      rchk("status on", ADDR_STATUS, 32'h0000_0020);
      wr(ADDR_DATA, {24'h0, lfsr[15:8]});
      @(posedge sck_out);
      t1 = $time;
      @(posedge sck_out);
      cmp_word("sck period", period(p, r), 32'(($time - t1) / 25));
      rchk("rate busy", ADDR_RATE, c);
      wr(ADDR_CTRL1, 32'h0000_0000);
      rchk("status off", ADDR_STATUS, 32'h0000_0020);
      cmp_bit("select off", 1'b1, select_n_out);
    end
    // every master, fault-enable and select-output setting against a low select
    for (int k = 0; k < 8; k++) begin
      c = {24'h0, 2'h3, 1'b0, k[1], 2'h0, k[0], 1'b0};
      f = k[2] & k[1] & ~k[0];
      wr(ADDR_CTRL2, {27'h0, k[2], 4'h0});
      wr(ADDR_CTRL1, c);
      @(posedge ref_clk);
      cmp_bit("select oe", k[2] & k[1] & k[0], select_oe);
      select_n_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
      select_n_in <= 1'b1;
      wr(ADDR_CTRL1, c);
      rchk("fault", ADDR_STATUS, {24'h0, 3'h1, f, 4'h0});
      cmp_bit("fault irq", f, rx_irq);
      wr(ADDR_CTRL1, c);
      rchk("fault clr", ADDR_STATUS, 32'h0000_0020);
    end
    wrap_up();
  end
endmodule
